/* src/isac_pkg.sv */
// Function
// - wait timing select and ack enable reset to 0, change only by software
// - wait and interrupt at eighth falling edge, or ninth for a data byte when select is 1 or on own address match
// - with ack enable set, data line driven low in ninth clock of received data byte
// - slave address reception ignores ack enable, acks on own address match
// - extension code acknowledged only when ack enable is set
// - ack enable and wait select have no bus effect while interface disabled
// - start trigger on free bus makes start: data falls while clock high
// - after start, hold time elapses before clock line is pulled low
// - trigger on busy bus with reservation enabled becomes pending start
// - pending start fires automatically once the bus is released
// - trigger on busy bus with reservation disabled sets fail flag, clears trigger
// - trigger set by master in wait gives repeated start after wait release
// - trigger clears after start, on arbitration loss, bus release, disable, reset
package isac_pkg;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS   = 20;
  localparam int HOLD_STD_NS     = 4000;
  localparam int HOLD_FAST_NS    = 600;
  localparam int HOLD_STD_CYC    = (HOLD_STD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_FAST_CYC   = (HOLD_FAST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_W          = 8;

  // ----------------------------------------
  // byte framing
  // ----------------------------------------
  localparam logic [3:0] FALL_DATA_DONE = 4'h7;
  localparam logic [3:0] FALL_ACK_DONE  = 4'h8;
  localparam logic [3:0] EXT_CODE_HI    = 4'h0;
  localparam int         DATA_W         = 8;
  localparam int         FIFO_DEPTH     = 32;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef struct packed {
    logic interface_enable;
    logic ack_enable_set;
    logic ack_enable_clr;
    logic wts_set;
    logic wts_clr;
    logic start_trigger_wr;
    logic reservation_disable;
    logic wait_release;
    logic release_bus;
    logic fast_mode;
    logic start_fail_clr;
  } isac_ctrl_t;

  typedef struct packed {
    logic start_trigger;
    logic start_fail_flag;
    logic ack_enable;
    logic wait_timing_select;
    logic bus_busy;
    logic master_active;
    logic in_wait;
    logic wait_event;
    logic arb_lost;
  } isac_stat_t;

  typedef enum logic [2:0] {
    M_IDLE   = 3'b000,
    M_START  = 3'b001,
    M_WAIT   = 3'b010,
    M_RS_SDA = 3'b011,
    M_RS_SCL = 3'b100
  } isac_mstate_t;

  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_XFER = 2'b01,
    S_WAIT = 2'b10
  } isac_sstate_t;

endpackage

/* src/isac_fifo.sv */
`timescale 1ns/1ns
module isac_fifo
  import isac_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // clock and reset
  input  wire logic             clock,
  input  wire logic             rst_b,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic [AW:0]      count_next;
  logic             push;
  logic             pop;

  assign push     = in_valid && in_ready;
  assign pop      = out_valid && out_ready;
  assign out_data = mem_reg[rd_ptr_reg];

  always_comb begin
    count_next = count_reg;
    if (push && !pop) begin
      count_next = count_reg + (AW+1)'(1);
    end else if (pop && !push) begin
      count_next = count_reg - (AW+1)'(1);
    end
  end

  // flags registered from the next count so they stay honest on the same edge
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      count_reg  <= '0;
      in_ready   <= 1'b0;
      out_valid  <= 1'b0;
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      count_reg <= count_next;
      in_ready  <= count_next != (AW+1)'(DEPTH);
      out_valid <= count_next != '0;
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + AW'(1);
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + AW'(1);
      end
    end
  end

  always_ff @(posedge clock) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

endmodule

/* src/isac_top.sv */
`timescale 1ns/1ns
module isac_top
  import isac_pkg::*;
(
  // clock and reset
  input  wire logic              clock,
  input  wire logic              rst_b,
  // software control and status
  input  wire isac_ctrl_t        ctrl,
  input  wire logic [6:0]        own_address,
  output isac_stat_t             stat,
  // received data stream
  output logic                   rx_valid,
  input  wire logic              rx_ready,
  output logic [DATA_W-1:0]      rx_data,
  // bus pins
  input  wire logic              clock_line_pin_in,
  output logic                   clock_line_pin_out,
  output logic                   clock_line_pin_oe,
  input  wire logic              data_line_pin_in,
  output logic                   data_line_pin_out,
  output logic                   data_line_pin_oe
);

  // ----------------------------------------
  // reset release and pin synchronisers
  // ----------------------------------------
  logic rst_s1_reg;
  logic rst_sync_b;
  logic scl_s1_reg;
  logic scl_s2_reg;
  logic scl_q_reg;
  logic sda_s1_reg;
  logic sda_s2_reg;
  logic sda_q_reg;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rst_s1_reg <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_sync_b <= rst_s1_reg;
    end
  end

  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      scl_s1_reg <= 1'b1;
      scl_s2_reg <= 1'b1;
      scl_q_reg  <= 1'b1;
      sda_s1_reg <= 1'b1;
      sda_s2_reg <= 1'b1;
      sda_q_reg  <= 1'b1;
    end else begin
      scl_s1_reg <= clock_line_pin_in;
      scl_s2_reg <= scl_s1_reg;
      scl_q_reg  <= scl_s2_reg;
      sda_s1_reg <= data_line_pin_in;
      sda_s2_reg <= sda_s1_reg;
      sda_q_reg  <= sda_s2_reg;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  assign scl_rise  = scl_s2_reg && !scl_q_reg;
  assign scl_fall  = !scl_s2_reg && scl_q_reg;
  assign start_det = scl_s2_reg && scl_q_reg && sda_q_reg && !sda_s2_reg;
  assign stop_det  = scl_s2_reg && scl_q_reg && !sda_q_reg && sda_s2_reg;

  // ----------------------------------------
  // software bits and bus state
  // ----------------------------------------
  logic ie;
  logic ack_enable_reg;
  logic wts_reg;
  logic bus_busy_reg;

  assign ie = ctrl.interface_enable;

  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      ack_enable_reg <= 1'b0;
      wts_reg        <= 1'b0;
    end else begin
      if (ctrl.ack_enable_set) begin
        ack_enable_reg <= 1'b1;
      end else if (ctrl.ack_enable_clr) begin
        ack_enable_reg <= 1'b0;
      end
      if (ctrl.wts_set) begin
        wts_reg <= 1'b1;
      end else if (ctrl.wts_clr) begin
        wts_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      bus_busy_reg <= 1'b0;
    end else if (!ie || stop_det) begin
      bus_busy_reg <= 1'b0;
    end else if (start_det) begin
      bus_busy_reg <= 1'b1;
    end
  end

  // ----------------------------------------
  // master start generation
  // ----------------------------------------
  isac_mstate_t     mstate_reg;
  logic             trig_reg;
  logic [HOLD_W-1:0] hold_cnt_reg;
  logic [HOLD_W-1:0] hold_len;
  logic             m_sda_drv_reg;
  logic             m_scl_drv_reg;
  logic             arb_lost_reg;
  logic             fail_set;
  logic             start_fail_reg;

  // speed picks the hold; fast mode trades margin for throughput
  assign hold_len = ctrl.fast_mode ? HOLD_W'(HOLD_FAST_CYC) : HOLD_W'(HOLD_STD_CYC);
  assign fail_set = ie && mstate_reg == M_IDLE && ctrl.start_trigger_wr
                    && bus_busy_reg && ctrl.reservation_disable;

  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      mstate_reg    <= M_IDLE;
      trig_reg      <= 1'b0;
      hold_cnt_reg  <= '0;
      m_sda_drv_reg <= 1'b0;
      m_scl_drv_reg <= 1'b0;
      arb_lost_reg  <= 1'b0;
    end else if (!ie || ctrl.release_bus) begin
      mstate_reg    <= M_IDLE;
      trig_reg      <= 1'b0;
      m_sda_drv_reg <= 1'b0;
      m_scl_drv_reg <= 1'b0;
      arb_lost_reg  <= 1'b0;
    end else begin
      arb_lost_reg <= 1'b0;
      case (mstate_reg)
        M_IDLE: begin
          if ((ctrl.start_trigger_wr || trig_reg) && !bus_busy_reg) begin
            mstate_reg    <= M_START;
            trig_reg      <= 1'b1;
            m_sda_drv_reg <= 1'b1;
            hold_cnt_reg  <= hold_len;
          end else if (ctrl.start_trigger_wr && !ctrl.reservation_disable) begin
            trig_reg <= 1'b1;
          end else if (fail_set) begin
            trig_reg <= 1'b0;
          end
        end
        M_START: begin
          if (hold_cnt_reg == '0) begin
            mstate_reg    <= M_WAIT;
            m_scl_drv_reg <= 1'b1;
            trig_reg      <= 1'b0;
          end else begin
            hold_cnt_reg <= hold_cnt_reg - HOLD_W'(1);
          end
        end
        M_WAIT: begin
          if (ctrl.start_trigger_wr) begin
            trig_reg <= 1'b1;
          end
          if ((trig_reg || ctrl.start_trigger_wr) && ctrl.wait_release) begin
            mstate_reg    <= M_RS_SDA;
            m_sda_drv_reg <= 1'b0;
            hold_cnt_reg  <= hold_len;
          end
        end
        M_RS_SDA: begin
          if (hold_cnt_reg == '0) begin
            mstate_reg    <= M_RS_SCL;
            m_scl_drv_reg <= 1'b0;
            hold_cnt_reg  <= hold_len;
          end else begin
            hold_cnt_reg <= hold_cnt_reg - HOLD_W'(1);
          end
        end
        M_RS_SCL: begin
          if (!sda_s2_reg) begin
            mstate_reg   <= M_IDLE;
            trig_reg     <= 1'b0;
            arb_lost_reg <= 1'b1;
          end else if (scl_s2_reg) begin
            if (hold_cnt_reg == '0) begin
              mstate_reg    <= M_START;
              m_sda_drv_reg <= 1'b1;
              hold_cnt_reg  <= hold_len;
            end else begin
              hold_cnt_reg <= hold_cnt_reg - HOLD_W'(1);
            end
          end
        end
        default: begin
          mstate_reg <= M_IDLE;
        end
      endcase
    end
  end

  // set wins over a clear in the same cycle
  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      start_fail_reg <= 1'b0;
    end else if (fail_set) begin
      start_fail_reg <= 1'b1;
    end else if (ctrl.start_fail_clr || !ie) begin
      start_fail_reg <= 1'b0;
    end
  end

  // ----------------------------------------
  // slave receiver, ack and wait
  // ----------------------------------------
  isac_sstate_t      sstate_reg;
  logic [3:0]        fall_cnt_reg;
  logic [DATA_W-1:0] shift_reg;
  logic              is_addr_reg;
  logic              ack_drv_reg;
  logic              wait_evt_reg;
  logic              push_valid_reg;
  logic [DATA_W-1:0] push_data_reg;
  logic              push_ready;
  logic              addr_match;
  logic              ext_code;

  assign addr_match = shift_reg[7:1] == own_address;
  assign ext_code   = shift_reg[7:4] == EXT_CODE_HI;

  // receive only: the direction bit is not acted on here
  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      sstate_reg     <= S_IDLE;
      fall_cnt_reg   <= '0;
      shift_reg      <= '0;
      is_addr_reg    <= 1'b0;
      ack_drv_reg    <= 1'b0;
      wait_evt_reg   <= 1'b0;
      push_valid_reg <= 1'b0;
      push_data_reg  <= '0;
    end else if (!ie || ctrl.release_bus || stop_det || mstate_reg != M_IDLE) begin
      sstate_reg     <= S_IDLE;
      ack_drv_reg    <= 1'b0;
      wait_evt_reg   <= 1'b0;
      push_valid_reg <= push_valid_reg && !push_ready;
    end else begin
      wait_evt_reg <= 1'b0;
      if (push_valid_reg && push_ready) begin
        push_valid_reg <= 1'b0;
      end
      if (start_det) begin
        sstate_reg   <= S_XFER;
        is_addr_reg  <= 1'b1;
        // the start's own clock fall wraps this to zero, so only bit clocks count
        fall_cnt_reg <= '1;
        ack_drv_reg  <= 1'b0;
      end else begin
        case (sstate_reg)
          S_XFER: begin
            if (scl_rise) begin
              shift_reg <= {shift_reg[DATA_W-2:0], sda_s2_reg};
            end
            if (scl_fall && fall_cnt_reg == FALL_DATA_DONE) begin
              fall_cnt_reg <= fall_cnt_reg + 4'h1;
              if (is_addr_reg) begin
                ack_drv_reg <= addr_match || (ext_code && ack_enable_reg);
                if (ext_code) begin
                  sstate_reg   <= S_WAIT;
                  wait_evt_reg <= 1'b1;
                end else if (!addr_match) begin
                  sstate_reg <= S_IDLE;
                end
              end else begin
                ack_drv_reg    <= ack_enable_reg;
                push_valid_reg <= 1'b1;
                push_data_reg  <= shift_reg;
                if (!wts_reg) begin
                  sstate_reg   <= S_WAIT;
                  wait_evt_reg <= 1'b1;
                end
              end
            end else if (scl_fall && fall_cnt_reg == FALL_ACK_DONE) begin
              fall_cnt_reg <= '0;
              ack_drv_reg  <= 1'b0;
              is_addr_reg  <= 1'b0;
              if (is_addr_reg || wts_reg) begin
                sstate_reg   <= S_WAIT;
                wait_evt_reg <= 1'b1;
              end
            end else if (scl_fall) begin
              fall_cnt_reg <= fall_cnt_reg + 4'h1;
            end
          end
          S_WAIT: begin
            if (ctrl.wait_release) begin
              sstate_reg <= S_XFER;
            end
          end
          default: begin
            sstate_reg <= S_IDLE;
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // received byte buffer
  // ----------------------------------------
  isac_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) i_isac_fifo (
    .clock     (clock),
    .rst_b     (rst_sync_b),
    .in_valid  (push_valid_reg),
    .in_ready  (push_ready),
    .in_data   (push_data_reg),
    .out_valid (rx_valid),
    .out_ready (rx_ready),
    .out_data  (rx_data)
  );

  // ----------------------------------------
  // pin drivers and status
  // ----------------------------------------
  // a full buffer stretches the clock line, so the sender is held off
  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      clock_line_pin_out <= 1'b0;
      clock_line_pin_oe  <= 1'b0;
      data_line_pin_out  <= 1'b0;
      data_line_pin_oe   <= 1'b0;
    end else begin
      clock_line_pin_out <= 1'b0;
      data_line_pin_out  <= 1'b0;
      clock_line_pin_oe  <= ie && (m_scl_drv_reg || sstate_reg == S_WAIT
                            || (push_valid_reg && !push_ready));
      data_line_pin_oe   <= ie && (m_sda_drv_reg || ack_drv_reg);
    end
  end

  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      stat <= '0;
    end else begin
      stat.start_trigger      <= trig_reg;
      stat.start_fail_flag    <= start_fail_reg;
      stat.ack_enable         <= ack_enable_reg;
      stat.wait_timing_select <= wts_reg;
      stat.bus_busy           <= bus_busy_reg;
      stat.master_active      <= mstate_reg != M_IDLE;
      stat.in_wait            <= sstate_reg == S_WAIT || mstate_reg == M_WAIT;
      stat.wait_event         <= wait_evt_reg;
      stat.arb_lost           <= arb_lost_reg;
    end
  end

endmodule

/* dv/isac_props.sv */
`timescale 1ns/1ns
module isac_props
  import isac_pkg::*;
(
  // clock and reset
  input wire logic       clock,
  input wire logic       rst_b,
  // software side
  input wire isac_ctrl_t ctrl,
  input wire isac_stat_t stat,
  // bus pins
  input wire logic       clock_line_pin_in,
  input wire logic       clock_line_pin_oe,
  input wire logic       data_line_pin_oe
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  // ----------------------------------------
  // start hold counter
  // ----------------------------------------
  // too long to unroll, so cycles with data driven and clock free are counted
  logic [8:0] hold_cnt;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      hold_cnt <= '0;
    end else if (!data_line_pin_oe || clock_line_pin_oe) begin
      hold_cnt <= '0;
    end else if (hold_cnt != 9'h1FF) begin
      hold_cnt <= hold_cnt + 9'h001;
    end
  end

  // ----------------------------------------
  // properties
  // ----------------------------------------
  sequence s_trig_busy;
    ctrl.start_trigger_wr && ctrl.interface_enable && stat.bus_busy && !stat.master_active;
  endsequence
  sequence s_trig_free;
    ctrl.start_trigger_wr && ctrl.interface_enable && !stat.bus_busy && !stat.master_active
      && !stat.start_trigger;
  endsequence
  property p_rst;
    $rose(rst_b) |-> stat == '0 && !clock_line_pin_oe && !data_line_pin_oe;
  endproperty
  property p_ack_set;
    ctrl.ack_enable_set && ctrl.interface_enable |-> ##2 stat.ack_enable;
  endproperty
  property p_ack_clr;
    ctrl.ack_enable_clr && !ctrl.ack_enable_set && ctrl.interface_enable |-> ##2 !stat.ack_enable;
  endproperty
  property p_ack_keep;
    !ctrl.ack_enable_set && !ctrl.ack_enable_clr |-> ##2 $stable(stat.ack_enable);
  endproperty
  property p_wts_set;
    ctrl.wts_set && ctrl.interface_enable |-> ##2 stat.wait_timing_select;
  endproperty
  property p_quiet;
    !ctrl.interface_enable [*3] |-> !clock_line_pin_oe && !data_line_pin_oe;
  endproperty
  property p_hold;
    $rose(clock_line_pin_oe) && stat.master_active
      |-> hold_cnt >= (ctrl.fast_mode ? HOLD_FAST_CYC : HOLD_STD_CYC);
  endproperty
  property p_fail;
    s_trig_busy ##0 ctrl.reservation_disable |-> ##2 stat.start_fail_flag && !stat.start_trigger;
  endproperty
  property p_reserve;
    s_trig_busy ##0 !ctrl.reservation_disable |-> ##2 stat.start_trigger;
  endproperty
  property p_free;
    s_trig_free |-> ##2 data_line_pin_oe && !clock_line_pin_oe && clock_line_pin_in;
  endproperty
  property p_trig_clr;
    $rose(clock_line_pin_oe) && stat.master_active |-> ##[0:3] !stat.start_trigger;
  endproperty
  property p_wait_evt;
    stat.wait_event |-> stat.in_wait && !stat.master_active;
  endproperty
  a_rst: assert property (p_rst) else $error("state not clear after reset");
  a_ack_set: assert property (p_ack_set) else $error("ack enable not set");
  a_ack_clr: assert property (p_ack_clr) else $error("ack enable not cleared");
  a_ack_keep: assert property (p_ack_keep) else $error("ack enable changed alone");
  a_wts_set: assert property (p_wts_set) else $error("wait select not set");
  a_quiet: assert property (p_quiet) else $error("bus driven while disabled");
  a_hold: assert property (p_hold) else $error("start hold too short");
  a_fail: assert property (p_fail) else $error("busy start not refused");
  a_reserve: assert property (p_reserve) else $error("start not reserved");
  a_free: assert property (p_free) else $error("no start on free bus");
  a_trig_clr: assert property (p_trig_clr) else $error("trigger not cleared");
  a_wait_evt: assert property (p_wait_evt) else $error("wait event without wait");
endmodule

bind isac_top isac_props i_isac_props (
  .clock             (clock),
  .rst_b             (rst_b),
  .ctrl              (ctrl),
  .stat              (stat),
  .clock_line_pin_in (clock_line_pin_in),
  .clock_line_pin_oe (clock_line_pin_oe),
  .data_line_pin_oe  (data_line_pin_oe)
);

/* dv/isac_bus_model.sv */
`timescale 1ns/1ns
module isac_bus_model (
  // bus wires, drive high pulls the line low
  input  wire logic clock_line,
  input  wire logic data_line,
  output logic      clock_drive,
  output logic      data_drive
);
  // ----------------------------------------
  // other master, 160 ns bit time
  // ----------------------------------------
  initial begin
    clock_drive = 1'b0;
    data_drive  = 1'b0;
  end
  task automatic bit_cycle(input logic b, output logic seen);
    int n;
    #40 data_drive = ~b;
    #40 clock_drive = 1'b0;
    // stretched clock is waited out, bounded against a stuck line
    for (n = 0; n < 9000 && clock_line !== 1'b1; n++) #10;
    #80 seen = data_line;
    clock_drive = 1'b1;
  endtask
  task automatic start_cond;
    data_drive = 1'b0;
    clock_drive = 1'b0;
    #80 data_drive = 1'b1;
    #80 clock_drive = 1'b1;
  endtask
  // clock is pulled low first so an idle bus never sees a false start
  task automatic stop_cond;
    int n;
    clock_drive = 1'b1;
    #40 data_drive = 1'b1;
    #40 clock_drive = 1'b0;
    // a slave still stretching the clock is waited out before the stop edge
    for (n = 0; n < 9000 && clock_line !== 1'b1; n++) #10;
    #80 data_drive = 1'b0;
    #200;
  endtask
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_cycle(b[i], s);
    bit_cycle(1'b1, ack);
  endtask
endmodule

/* dv/isac_top_bench.sv */
`timescale 1ns/1ns
module isac_top_bench
  import isac_pkg::*;
();
  // ----------------------------------------
  // design and far side
  // ----------------------------------------
  localparam int AE_SET = 9, AE_CLR = 8, WT_SET = 7, WT_CLR = 6, TRIG = 5, WREL = 3, RELB = 2;
  localparam int FCLR = 0;
  logic              clock = 1'b0;
  logic              rst_b = 1'b0;
  isac_ctrl_t        ctrl = '0;
  logic [6:0]        own_address = 7'h2A;
  isac_stat_t        stat;
  logic              rx_valid;
  logic              rx_ready = 1'b0;
  logic [DATA_W-1:0] rx_data;
  logic              c_out, c_oe, d_out, d_oe, m_c, m_d, ack;
  logic              auto_rel = 1'b0;
  int                bad_count = 0;
  int                tests_run = 0;
  int                n, k;
  wire               scl = ~(c_oe | m_c);
  wire               sda = ~(d_oe | m_d);

  always #10 clock = ~clock;

  isac_top i_isac_top (.clock(clock), .rst_b(rst_b), .ctrl(ctrl), .own_address(own_address),
    .stat(stat), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data),
    .clock_line_pin_in(scl), .clock_line_pin_out(c_out), .clock_line_pin_oe(c_oe),
    .data_line_pin_in(sda), .data_line_pin_out(d_out), .data_line_pin_oe(d_oe));
  isac_bus_model i_isac_bus_model (.clock_line(scl), .data_line(sda), .clock_drive(m_c),
    .data_drive(m_d));

  // slave waits released as they come; off while the master wait is tested
  always @(negedge clock) begin
    if (auto_rel) begin
      ctrl.wait_release <= (stat.in_wait === 1'b1) && !ctrl.wait_release;
    end
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out;
    if (bad_count == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic limit(input int cnt, input int lim);
    if (cnt >= lim) begin
      bad_count++;
      close_out();
    end
  endtask
  task automatic pulse(input int b);
    @(negedge clock);
    ctrl[b] = 1'b1;
    @(negedge clock);
    ctrl[b] = 1'b0;
    repeat (2) @(negedge clock);
  endtask
  task automatic master_hold;
    for (n = 0; n < 900 && c_oe !== 1'b1; n++) @(negedge clock);
    limit(n, 900);
    repeat (3) @(negedge clock);
    check("trigger after start", 8'(stat.start_trigger), 8'h00);
  endtask
  task automatic frame(input logic [7:0] b, input logic exp, input string what);
    i_isac_bus_model.start_cond();
    i_isac_bus_model.send_byte(b, ack);
    check(what, 8'(ack), 8'(exp));
    i_isac_bus_model.stop_cond();
  endtask

  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    repeat (2) @(negedge clock);
    rst_b = 1'b1;
    repeat (3) @(negedge clock);
    check("stat after reset", 8'(stat === '0), 8'h01);
    ctrl.interface_enable = 1'b1;
    auto_rel = 1'b1;
    pulse(AE_SET);
    check("ack_enable set", 8'(stat.ack_enable), 8'h01);
    pulse(AE_CLR);
    check("ack_enable clear", 8'(stat.ack_enable), 8'h00);
    pulse(WT_SET);
    check("wait select set", 8'(stat.wait_timing_select), 8'h01);
    i_isac_bus_model.start_cond();
    i_isac_bus_model.send_byte({own_address, 1'b0}, ack);
    check("address ack", 8'(ack), 8'h00);
    pulse(AE_SET);
    pulse(WT_CLR);
    fork
      for (int i = 0; i < 33; i++) begin
        i_isac_bus_model.send_byte(8'(i + 8'h40), ack);
        check("data ack", 8'(ack), 8'h00);
      end
      begin
        k = 0;
        for (n = 0; n < 9000 && k < 200; n++) begin
          @(negedge clock);
          k = (scl === 1'b0) ? k + 1 : 0;
        end
        check("full buffer stalls bus", 8'(k), 8'hC8);
        rx_ready = 1'b1;
        for (int i = 0; i < 33; i++) begin
          for (n = 0; n < 2000 && rx_valid !== 1'b1; n++) @(negedge clock);
          limit(n, 2000);
          check("rx data", rx_data, 8'(i + 8'h40));
          @(negedge clock);
        end
      end
    join
    pulse(AE_CLR);
    i_isac_bus_model.send_byte(8'hC3, ack);
    check("data nack", 8'(ack), 8'h01);
    i_isac_bus_model.stop_cond();
    for (int e = 0; e < 2; e++) begin
      frame(8'h0A, e == 0, "extension code ack");
      pulse(AE_SET);
    end
    @(negedge clock);
    ctrl.interface_enable = 1'b0;
    frame({own_address, 1'b0}, 1'b1, "ack while disabled");
    @(negedge clock);
    ctrl.interface_enable = 1'b1;
    check("ack_enable kept", 8'(stat.ack_enable), 8'h01);
    i_isac_bus_model.start_cond();
    i_isac_bus_model.send_byte(8'hB4, ack);
    check("foreign address", 8'(ack), 8'h01);
    @(negedge clock);
    ctrl.reservation_disable = 1'b1;
    pulse(TRIG);
    check("busy start refused", 8'({stat.start_fail_flag, stat.start_trigger}), 8'h02);
    ctrl.reservation_disable = 1'b0;
    pulse(FCLR);
    pulse(TRIG);
    check("start reserved", 8'({stat.start_trigger, d_oe}), 8'h02);
    @(negedge clock);
    auto_rel = 1'b0;
    @(negedge clock);
    ctrl.wait_release = 1'b0;
    i_isac_bus_model.stop_cond();
    for (n = 0; n < 400 && d_oe !== 1'b1; n++) @(negedge clock);
    limit(n, 400);
    check("reserved start", 8'({d_oe, scl}), 8'h03);
    master_hold();
    pulse(TRIG);
    pulse(WREL);
    for (n = 0; n < 900 && d_oe !== 1'b0; n++) @(negedge clock);
    for (k = 0; k < 900 && d_oe !== 1'b1; k++) @(negedge clock);
    limit(n + k, 900);
    check("restart", 8'({d_oe, scl}), 8'h03);
    master_hold();
    pulse(RELB);
    check("released", 8'({c_oe, d_oe, stat.start_trigger}), 8'h00);
    check("pin out levels", 8'({c_out, d_out}), 8'h00);
    i_isac_bus_model.stop_cond();
    for (int f = 0; f < 2; f++) begin
      @(negedge clock);
      ctrl.fast_mode = f[0];
      pulse(TRIG);
      check("start pins", 8'({d_oe, c_oe, scl}), 8'h05);
      for (n = 0; n < 400 && c_oe !== 1'b1; n++) @(negedge clock);
      check("start hold", 8'(n), 8'(f ? HOLD_FAST_CYC : HOLD_STD_CYC));
      ctrl.interface_enable = 1'b0;
      repeat (3) @(negedge clock);
      check("disable clears", 8'({c_oe, d_oe, stat.start_trigger}), 8'h00);
      ctrl.interface_enable = 1'b1;
      i_isac_bus_model.stop_cond();
    end
    close_out();
  end
endmodule
